// File: design/line_alarm_status_irq_latch.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - status bit 7 follows the system-side alarm indication detector
// - status bit 6 follows the line-side alarm indication detector
// - status bit 5 is one while the test pattern checker is in sync
// - bit 1 sets after activate code lasts over 40 ms, or 5.1 s auto
// - bit 0 sets after deactivate code over 40/30 ms, or 5.1 s auto
// - second status register is read-only, resets zero, bits 4..2 zero
// - latch bits reset zero; writing one clears, zero leaves unchanged
// - any set latch bit whose mask bit is zero is reported on the interrupt output
// - latch bit 7 catches amplitude overflow events
// - latch bits 6 and 5 catch transmit and receive jitter FIFO events
// - bit 4 catches overcurrent rise, or both edges when select bit 4
// - bit 3 catches clock-missing rise, or both edges when select bit 3
// - bit 2 catches transmit loss rise, or both edges when select bit 2
// - bits 1 and 0 catch signal loss edges, both sharing select bit 1
// - sixteen channel copies, each spaced 0x40 register indices apart
// - mask bit one blocks its source from the pin; masks reset to one
module line_alarm_status_irq_latch
  import line_alarm_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic [NUM_CH-1:0] sys_alarm_ind_live,
  input  wire logic [NUM_CH-1:0] line_alarm_ind_live,
  input  wire logic [NUM_CH-1:0] pattern_sync_live,
  input  wire logic [NUM_CH-1:0] loop_up_code_det,
  input  wire logic [NUM_CH-1:0] loop_down_code_det,
  input  wire logic [NUM_CH-1:0] driver_overcurrent_live,
  input  wire logic [NUM_CH-1:0] tx_clk_missing_live,
  input  wire logic [NUM_CH-1:0] tx_sig_loss_live,
  input  wire logic [NUM_CH-1:0] sys_sig_loss_live,
  input  wire logic [NUM_CH-1:0] line_sig_loss_live,
  input  wire logic [NUM_CH-1:0] amp_overflow_evt,
  input  wire logic [NUM_CH-1:0] tx_jitter_fifo_evt,
  input  wire logic [NUM_CH-1:0] rx_jitter_fifo_evt,
  output logic      [NUM_CH-1:0] loop_up_code_live,
  output logic      [NUM_CH-1:0] loop_down_code_live
);

  // all detector inputs come from on-chip logic on pclk: no synchronisers

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] loop_limit(input logic auto_lp,
                                                   input logic e1,
                                                   input logic down);
    loop_limit = CNT_W'(LOOP_T1_MS);
    if (auto_lp) begin
      loop_limit = CNT_W'(LOOP_AUTO_MS);
    end else if (down && e1) begin
      loop_limit = CNT_W'(LOOP_E1_MS);
    end
  endfunction

  function automatic logic [CNT_W-1:0] loop_next(input logic det,
                                                  input logic tick,
                                                  input logic [CNT_W-1:0] cnt,
                                                  input logic [CNT_W-1:0] lim);
    loop_next = cnt;
    if (!det) begin
      loop_next = '0;
    end else if (tick && cnt <= lim) begin
      loop_next = cnt + CNT_W'(1);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [REG_W-1:0]  ints_q   [NUM_CH];
  logic [REG_W-1:0]  ints_d   [NUM_CH];
  logic [REG_W-1:0]  mask_q   [NUM_CH];
  logic [REG_W-1:0]  edge_q   [NUM_CH];
  logic [REG_W-1:0]  ctrl_q   [NUM_CH];
  logic [4:0]        prev_q   [NUM_CH];
  logic [CNT_W-1:0]  up_cnt_q [NUM_CH];
  logic [CNT_W-1:0]  dn_cnt_q [NUM_CH];
  logic [REG_W-1:0]  line_condition_status_w  [NUM_CH];
  logic [REG_W-1:0]  alarm_and_code_status_w  [NUM_CH];
  logic [REG_W-1:0]  set_w    [NUM_CH];
  logic [REG_W-1:0]  clr_w    [NUM_CH];
  logic [NUM_CH-1:0] pending_w;
  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick_q;
  logic [DATA_W-1:0] prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              irq_q;
  logic [NUM_CH-1:0] up_flag_q;
  logic [NUM_CH-1:0] dn_flag_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire              setup    = psel & ~penable;
  wire              access   = psel & penable & pready_q;
  wire [IDX_W-1:0]  idx      = paddr[ADDR_W-1:2];
  wire [CH_W-1:0]   ch       = idx[IDX_W-1 -: CH_W];
  wire [OFF_W-1:0]  off      = idx[OFF_W-1:0];
  wire              aligned  = (paddr[1:0] == 2'b00);
  wire              hit_mask = aligned && off == MASK0_IDX;
  wire              hit_st0  = aligned && off == LINE_CONDITION_STATUS_IDX;
  wire              hit_st1  = aligned && off == ALARM_AND_CODE_STATUS_IDX;
  wire              hit_ints = aligned && off == LINE_EVENT_INTERRUPT_LATCH_IDX;
  wire              hit_edge = aligned && off == EDGE_IDX;
  wire              hit_ctrl = aligned && off == CTRL_IDX;
  wire              mapped   = hit_mask | hit_st0 | hit_st1 | hit_ints
                               | hit_edge | hit_ctrl;
  wire              wr       = access & pwrite & mapped;
  // status registers ignore writes: read-only
  wire [REG_W-1:0]  rd_byte  =
      hit_st1  ? alarm_and_code_status_w[ch] :
      hit_st0  ? line_condition_status_w[ch] :
      hit_ints ? ints_q[ch]  :
      hit_mask ? mask_q[ch]  :
      hit_edge ? edge_q[ch]  :
      hit_ctrl ? ctrl_q[ch]  : '0;
  wire [DATA_W-1:0] rd_val   = {{(DATA_W-REG_W){1'b0}}, rd_byte};

  // ----------------------------------------------------------------
  // per-channel logic
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    wire [4:0] now_w  = {driver_overcurrent_live[c], tx_clk_missing_live[c],
                         tx_sig_loss_live[c], sys_sig_loss_live[c],
                         line_sig_loss_live[c]};
    wire [4:0] both_w = {edge_q[c][B_TOC], edge_q[c][B_TCK],
                         edge_q[c][B_TLOS], edge_q[c][B_LOS],
                         edge_q[c][B_LOS]};
    // rise always counts; fall only where both edges are selected
    wire [4:0] evt_w  = (now_w & ~prev_q[c])
                        | (~now_w & prev_q[c] & both_w);
    wire       sel_w  = (ch == CH_W'(c));
    wire [CNT_W-1:0] up_lim = loop_limit(ctrl_q[c][C_AUTO],
                                         ctrl_q[c][C_E1], 1'b0);
    wire [CNT_W-1:0] dn_lim = loop_limit(ctrl_q[c][C_AUTO],
                                         ctrl_q[c][C_E1], 1'b1);

    assign alarm_and_code_status_w[c] = {sys_alarm_ind_live[c],
                         line_alarm_ind_live[c],
                         pattern_sync_live[c],
                         3'b000,
                         up_flag_q[c], dn_flag_q[c]};
    assign line_condition_status_w[c] = {3'b000, now_w};
    // pulse sources: amplitude, tx jitter, rx jitter
    assign set_w[c]   = {amp_overflow_evt[c],
                         tx_jitter_fifo_evt[c],
                         rx_jitter_fifo_evt[c],
                         evt_w};
    assign clr_w[c]   = (wr && hit_ints && sel_w) ? pwdata[REG_W-1:0]
                                                  : '0;
    // set wins over clear so no event is lost
    assign ints_d[c]  = (ints_q[c] & ~clr_w[c]) | set_w[c];
    assign pending_w[c] = |(ints_q[c] & ~mask_q[c]);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ints_q[c]   <= INTS_RST;
        mask_q[c]   <= MASK_RST;
        edge_q[c]   <= EDGE_RST;
        ctrl_q[c]   <= CTRL_RST;
        prev_q[c]   <= '0;
      end else begin
        ints_q[c]   <= ints_d[c];
        prev_q[c]   <= now_w;
        if (wr && sel_w && hit_mask) begin
          mask_q[c] <= pwdata[REG_W-1:0];
        end
        if (wr && sel_w && hit_edge) begin
          edge_q[c] <= pwdata[REG_W-1:0] & EDGE_USED;
        end
        if (wr && sel_w && hit_ctrl) begin
          ctrl_q[c] <= pwdata[REG_W-1:0] & CTRL_USED;
        end
      end
    end

    // persistence timers count 1 ms ticks while the code is seen
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        up_cnt_q[c]  <= '0;
        dn_cnt_q[c]  <= '0;
        up_flag_q[c] <= 1'b0;
        dn_flag_q[c] <= 1'b0;
      end else begin
        up_cnt_q[c]  <= loop_next(loop_up_code_det[c], tick_q,
                                  up_cnt_q[c], up_lim);
        dn_cnt_q[c]  <= loop_next(loop_down_code_det[c], tick_q,
                                  dn_cnt_q[c], dn_lim);
        up_flag_q[c] <= loop_up_code_det[c]
                        && up_cnt_q[c] > up_lim;
        dn_flag_q[c] <= loop_down_code_det[c]
                        && dn_cnt_q[c] > dn_lim;
      end
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == TICK_W'(TICK_CYCLES - 1))
                    ? '0 : tick_cnt_q + TICK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // apb answer and interrupt pin
  // ----------------------------------------------------------------
  // one wait-free access cycle: answer is prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
      irq_q     <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= pwrite ? '0 : rd_val;
      end
      irq_q     <= |pending_w;
    end
  end

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign irq                 = irq_q;
  assign loop_up_code_live   = up_flag_q;
  assign loop_down_code_live = dn_flag_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire rd_st1_ch0 = setup && !pwrite && hit_st1 && ch == '0;

  sys_alarm_read_a: assert property (
    rd_st1_ch0 |=> prdata_q[B_SAIS] == $past(sys_alarm_ind_live[0]))
    else $error("alarm bit 7 does not follow system alarm");
  line_alarm_read_a: assert property (
    rd_st1_ch0 |=> prdata_q[B_LAIS] == $past(line_alarm_ind_live[0]))
    else $error("alarm bit 6 does not follow line alarm");
  pattern_sync_read_a: assert property (
    rd_st1_ch0 |=> prdata_q[B_PA] == $past(pattern_sync_live[0]))
    else $error("bit 5 does not follow pattern sync");
  loop_up_time_a: assert property (
    $rose(up_flag_q[0]) |-> $past(up_cnt_q[0]) >
      $past(loop_limit(ctrl_q[0][C_AUTO], ctrl_q[0][C_E1], 1'b0)))
    else $error("activate code flag set too early");
  loop_down_time_a: assert property (
    $rose(dn_flag_q[0]) |-> $past(dn_cnt_q[0]) >
      $past(loop_limit(ctrl_q[0][C_AUTO], ctrl_q[0][C_E1], 1'b1)))
    else $error("deactivate code flag set too early");
  stat_reserved_a: assert property (
    rd_st1_ch0 |=> prdata_q[4:2] == 3'b000 && prdata_q[DATA_W-1:REG_W] == '0)
    else $error("reserved status bits not zero");
  w1c_clear_a: assert property (
    wr && hit_ints && ch == '0 && pwdata[B_LLOS] && !set_w[0][B_LLOS]
    |=> !ints_q[0][B_LLOS])
    else $error("write one did not clear latch bit");
  w1c_zero_keep_a: assert property (
    wr && hit_ints && ch == '0 && !pwdata[B_TOC] && ints_q[0][B_TOC]
    |=> ints_q[0][B_TOC])
    else $error("write zero changed latch bit");
  irq_report_a: assert property (
    ints_q[0][B_AMP] && !mask_q[0][B_AMP] |=> irq_q)
    else $error("unmasked latch bit not on interrupt pin");
  amp_latch_a: assert property (
    amp_overflow_evt[0] |=> ints_q[0][B_AMP])
    else $error("amplitude event not latched");
  toc_rise_a: assert property (
    $rose(driver_overcurrent_live[0]) |=> ints_q[0][B_TOC])
    else $error("overcurrent rise not latched");
  los_fall_a: assert property (
    $fell(line_sig_loss_live[0]) && edge_q[0][B_LOS] |=> ints_q[0][B_LLOS])
    else $error("line loss fall not latched with both edges");
  mask_block_a: assert property (
    (ints_q[0] & ~mask_q[0]) == '0 && pending_w[NUM_CH-1:1] == '0
    |=> !irq_q)
    else $error("interrupt raised with all sources masked");
  ch9_mask_wr_a: assert property (
    wr && hit_mask && ch == CH_W'(8) |=> mask_q[8] == $past(pwdata[REG_W-1:0]))
    else $error("channel 9 mask write lost");
  set_beats_clr_a: assert property (
    set_w[0][B_AMP] && clr_w[0][B_AMP] |=> ints_q[0][B_AMP])
    else $error("event lost under a clear");
  tx_jitter_latch_a: assert property (
    tx_jitter_fifo_evt[0] |=> ints_q[0][B_TXJIT])
    else $error("transmit jitter event not latched");
  rx_jitter_latch_a: assert property (
    rx_jitter_fifo_evt[0] |=> ints_q[0][B_RXJIT])
    else $error("receive jitter event not latched");
  toc_fall_a: assert property (
    $fell(driver_overcurrent_live[0]) && edge_q[0][B_TOC]
    |=> ints_q[0][B_TOC])
    else $error("overcurrent fall not latched with both edges");
  toc_rise_only_a: assert property (
    $fell(driver_overcurrent_live[0]) && !edge_q[0][B_TOC]
    && !ints_q[0][B_TOC] |=> !ints_q[0][B_TOC])
    else $error("overcurrent fall latched with rise only");
  clk_miss_rise_a: assert property (
    $rose(tx_clk_missing_live[0]) |=> ints_q[0][B_TCK])
    else $error("clock missing rise not latched");
  tx_loss_rise_a: assert property (
    $rose(tx_sig_loss_live[0]) |=> ints_q[0][B_TLOS])
    else $error("transmit loss rise not latched");
  sys_loss_rise_a: assert property (
    $rose(sys_sig_loss_live[0]) |=> ints_q[0][B_LOS])
    else $error("system loss rise not latched");
  loop_up_drop_a: assert property (
    !loop_up_code_det[0] |=> !up_flag_q[0])
    else $error("activate code flag stays without code");

  irq_rise_c:   cover property ($rose(irq_q));
  loop_up_c:    cover property ($rose(up_flag_q[0]));
  w1c_c:        cover property (wr && hit_ints && ints_q[0] != '0);
  slverr_c:     cover property (pslverr_q && access);
  los_fall_c:   cover property ($fell(line_sig_loss_live[0])
                                && edge_q[0][B_LOS]);

endmodule

// File: include/line_alarm_pkg.sv
package line_alarm_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH = 16;
  localparam int CH_W   = 4;
  localparam int IDX_W  = 10;
  localparam int ADDR_W = 12;
  localparam int OFF_W  = 6;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;

  // ----------------------------------------------------------------
  // register indices inside one channel (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [OFF_W-1:0] MASK0_IDX = 6'h1b;
  localparam logic [OFF_W-1:0] LINE_CONDITION_STATUS_IDX = 6'h1e;
  localparam logic [OFF_W-1:0] ALARM_AND_CODE_STATUS_IDX = 6'h1f;
  localparam logic [OFF_W-1:0] LINE_EVENT_INTERRUPT_LATCH_IDX = 6'h20;
  localparam logic [OFF_W-1:0] EDGE_IDX  = 6'h23;
  localparam logic [OFF_W-1:0] CTRL_IDX  = 6'h24;

  // ----------------------------------------------------------------
  // reset values and implemented bits
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] INTS_RST  = 8'h00;
  localparam logic [REG_W-1:0] MASK_RST  = 8'hff;
  localparam logic [REG_W-1:0] EDGE_RST  = 8'h00;
  localparam logic [REG_W-1:0] CTRL_RST  = 8'h00;
  localparam logic [REG_W-1:0] EDGE_USED = 8'h1e;
  localparam logic [REG_W-1:0] CTRL_USED = 8'h03;

  // status bit positions
  localparam int B_SAIS = 7;
  localparam int B_LAIS = 6;
  localparam int B_PA   = 5;
  localparam int B_IBA  = 1;
  localparam int B_IBD  = 0;
  // interrupt latch / edge select bit positions
  localparam int B_AMP  = 7;
  localparam int B_TXJIT = 6;
  localparam int B_RXJIT = 5;
  localparam int B_TOC  = 4;
  localparam int B_TCK  = 3;
  localparam int B_TLOS = 2;
  localparam int B_LOS  = 1;
  localparam int B_LLOS = 0;
  // control bits
  localparam int C_AUTO = 0;
  localparam int C_E1   = 1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 25_000_000;
  localparam int TICK_US         = 1000;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICK_W          = 16;
  localparam int CNT_W           = 13;
  localparam int LOOP_T1_MS      = 40;
  localparam int LOOP_E1_MS      = 30;
  localparam int LOOP_AUTO_MS    = 5100;

endpackage

// File: sim/line_alarm_status_irq_latch_tb.sv
`timescale 1ns/1ps

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
  end end

module line_alarm_status_irq_latch_tb;
  import line_alarm_pkg::*;

  // short tick keeps the 5100-tick loop timer inside the run budget
  localparam int TK = 4;

  logic              pclk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, r;
  logic              pready, pslverr, irq, e;
  logic [NUM_CH-1:0] sys_alarm_ind_live, line_alarm_ind_live;
  logic [NUM_CH-1:0] pattern_sync_live, loop_up_code_det, loop_down_code_det;
  logic [NUM_CH-1:0] driver_overcurrent_live, tx_clk_missing_live;
  logic [NUM_CH-1:0] tx_sig_loss_live, sys_sig_loss_live, line_sig_loss_live;
  logic [NUM_CH-1:0] amp_overflow_evt, tx_jitter_fifo_evt, rx_jitter_fifo_evt;
  logic [NUM_CH-1:0] loop_up_code_live, loop_down_code_live;
  logic [7:0]        sels [6];
  logic [7:0]        ex;
  int                n_mismatch, compares, cyc;

  line_alarm_status_irq_latch #(.TICK_CYCLES(TK)) u_line_alarm_status_irq_latch (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .sys_alarm_ind_live(sys_alarm_ind_live),
    .line_alarm_ind_live(line_alarm_ind_live),
    .pattern_sync_live(pattern_sync_live),
    .loop_up_code_det(loop_up_code_det),
    .loop_down_code_det(loop_down_code_det),
    .driver_overcurrent_live(driver_overcurrent_live),
    .tx_clk_missing_live(tx_clk_missing_live),
    .tx_sig_loss_live(tx_sig_loss_live),
    .sys_sig_loss_live(sys_sig_loss_live),
    .line_sig_loss_live(line_sig_loss_live),
    .amp_overflow_evt(amp_overflow_evt),
    .tx_jitter_fifo_evt(tx_jitter_fifo_evt),
    .rx_jitter_fifo_evt(rx_jitter_fifo_evt),
    .loop_up_code_live(loop_up_code_live),
    .loop_down_code_live(loop_down_code_live));

  // ----------------------------------------------------------------
  // clock, reset, timeout
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [11:0] ad(input int ch, input logic [5:0] idx);
    return {4'(ch - 1), idx, 2'b00};
  endfunction

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: the bench timeout ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] x);
    xfer(1'b0, a, 32'h0, r, e);
    `CHK(r, {24'h0, x})
  endtask

  task automatic set_live(input logic v);
    driver_overcurrent_live <= {15'h0, v};
    tx_clk_missing_live     <= {15'h0, v};
    tx_sig_loss_live        <= {15'h0, v};
    sys_sig_loss_live       <= {15'h0, v};
    line_sig_loss_live      <= {15'h0, v};
    repeat (3) @(posedge pclk);
  endtask

  task automatic loop_chk(input logic up, input logic [7:0] ctl,
                          input int lim);
    wr(ad(1, CTRL_IDX), ctl);
    if (up) loop_up_code_det <= 16'h1; else loop_down_code_det <= 16'h1;
    repeat ((lim - 2) * TK) @(posedge pclk);
    `CHK(up ? loop_up_code_live[0] : loop_down_code_live[0], 1'b0)
    repeat (8 * TK) @(posedge pclk);
    `CHK(up ? loop_up_code_live[0] : loop_down_code_live[0], 1'b1)
    rd_chk(ad(1, ALARM_AND_CODE_STATUS_IDX), up ? 8'hc2 : 8'hc1);
    loop_up_code_det <= '0;
    loop_down_code_det <= '0;
    repeat (3) @(posedge pclk);
    `CHK({loop_up_code_live[0], loop_down_code_live[0]}, 2'b00)
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sels = '{8'h00, 8'h10, 8'h08, 8'h04, 8'h02, 8'h1e};
    {presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
    {sys_alarm_ind_live, line_alarm_ind_live, pattern_sync_live} <= '0;
    {loop_up_code_det, loop_down_code_det, driver_overcurrent_live} <= '0;
    {tx_clk_missing_live, tx_sig_loss_live, sys_sig_loss_live} <= '0;
    {line_sig_loss_live, amp_overflow_evt, tx_jitter_fifo_evt} <= '0;
    rx_jitter_fifo_evt <= '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(ad(1, ALARM_AND_CODE_STATUS_IDX), 8'h00);
    rd_chk(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), INTS_RST);
    rd_chk(ad(1, MASK0_IDX), 8'hff);
    // live alarms on two channels, decoded by channel base
    sys_alarm_ind_live <= 16'h0100;
    line_alarm_ind_live <= 16'h0001;
    pattern_sync_live <= 16'h0001;
    repeat (2) @(posedge pclk);
    rd_chk(ad(1, ALARM_AND_CODE_STATUS_IDX), 8'h60);
    rd_chk(12'h87c, 8'h80);
    wr(ad(1, ALARM_AND_CODE_STATUS_IDX), 8'hff);
    rd_chk(ad(1, ALARM_AND_CODE_STATUS_IDX), 8'h60);
    sys_alarm_ind_live <= 16'h0001;
    pattern_sync_live <= '0;
    repeat (2) @(posedge pclk);
    rd_chk(ad(1, ALARM_AND_CODE_STATUS_IDX), 8'hc0);
    rd_chk(ad(9, ALARM_AND_CODE_STATUS_IDX), 8'h00);
    wr(ad(9, MASK0_IDX), 8'h5a);
    rd_chk(ad(9, MASK0_IDX), 8'h5a);
    rd_chk(ad(1, MASK0_IDX), 8'hff);
    xfer(1'b0, 12'h000, 32'h0, r, e);
    `CHK(e, 1'b1)
    xfer(1'b0, 12'h07d, 32'h0, r, e);
    `CHK(e, 1'b1)
    // one-cycle pulse sources, masked then unmasked
    amp_overflow_evt <= 16'h1;
    tx_jitter_fifo_evt <= 16'h1;
    rx_jitter_fifo_evt <= 16'h1;
    @(posedge pclk);
    {amp_overflow_evt, tx_jitter_fifo_evt, rx_jitter_fifo_evt} <= '0;
    repeat (3) @(posedge pclk);
    rd_chk(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), 8'he0);
    `CHK(irq, 1'b0)
    wr(ad(1, MASK0_IDX), 8'h7f);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b1)
    // jitter bits stay set but masked: pin must drop
    wr(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), 8'h80);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    wr(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), 8'h60);
    rd_chk(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), 8'h00);
    wr(ad(1, MASK0_IDX), 8'h00);
    amp_overflow_evt <= 16'h1;
    @(posedge pclk);
    amp_overflow_evt <= '0;
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), 8'h00);
    rd_chk(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), 8'h80);
    // clear lands on the same edge as a fresh pulse
    fork
      wr(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), 8'h80);
      begin
        repeat (2) @(posedge pclk);
        amp_overflow_evt <= 16'h1;
        @(posedge pclk);
        amp_overflow_evt <= '0;
      end
    join
    rd_chk(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), 8'h80);
    wr(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), 8'hff);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    // edge select: rise always latches, fall only when selected
    foreach (sels[i]) begin
      ex = (sels[i] & 8'h1c) | (sels[i][1] ? 8'h03 : 8'h00);
      wr(ad(1, EDGE_IDX), sels[i]);
      rd_chk(ad(1, EDGE_IDX), sels[i]);
      set_live(1'b1);
      rd_chk(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), 8'h1f);
      wr(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), 8'hff);
      set_live(1'b0);
      rd_chk(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), ex);
      wr(ad(1, LINE_EVENT_INTERRUPT_LATCH_IDX), 8'hff);
    end
    loop_chk(1'b1, 8'h00, LOOP_T1_MS);
    loop_chk(1'b0, 8'h00, LOOP_T1_MS);
    loop_chk(1'b0, 8'h02, LOOP_E1_MS);
    loop_chk(1'b1, 8'h01, LOOP_AUTO_MS);
    loop_chk(1'b0, 8'h03, LOOP_AUTO_MS);
    close_out();
  end

endmodule
